// file: rtl/dtmf_map.svh
// constants of the dtmf receive decoder: offsets, fields, resets, timing
// assumes a 100 MHz clock and word-aligned wishbone byte addresses
`ifndef DTMF_MAP_SVH
`define DTMF_MAP_SVH

`define CLK_HZ          100000000
`define CLK_MHZ         100
`define F_LOW0          697
`define F_LOW1          770
`define F_LOW2          852
`define F_LOW3          941
`define F_HIGH0         1209
`define F_HIGH1         1336
`define F_HIGH2         1477
`define F_HIGH3         1633
`define TOL_DIV         40
`define PER_W           18
`define CNT_W           24
`define GTP_TIME_US     30000
`define GTA_TIME_US     30000
`define SETTLE_TIME_NS  100
`define SETTLE_CYC      ((`SETTLE_TIME_NS * `CLK_MHZ + 999) / 1000)
`define SET_W           4

`define ADR_RX          8'h00
`define ADR_STATUS      8'h04
`define ADR_CTRL        8'h08
`define ADR_GTP         8'h0c
`define ADR_GTA         8'h10
`define ADR_EVENT       8'h14
`define ADR_MASK        8'h18

`define ST_EARLY        0
`define ST_GUARD        1
`define ST_VALID        2
`define ST_DSTEER       3
`define CTRL_IRQ_MODE   0
`define CTRL_EXT_STEER  1
`define EV_REG          0
`define EV_PAUSE        1
`define EV_REJECT       2
`define EV_W            3
`define CTRL_RST        2'h0
`define MASK_RST        3'h0

`endif

// file: rtl/dtmf_pkg.sv
// types shared by the dtmf receive decoder and its period meter
// assumes dtmf_map.svh is on the include path
`include "dtmf_map.svh"
package dtmf_pkg;

  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_PRESENT = 2'b01,
    ST_HELD    = 2'b11,
    ST_ABSENT  = 2'b10
  } steer_state_t;

  typedef struct packed {
    logic                tone;
    logic [`PER_W-1:0]   cnt;
    logic [`PER_W-1:0]   period;
    logic                stb;
    logic                over;
  } meter_t;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic [1:0]          lo_idx;
    logic                lo_ok;
    logic [1:0]          hi_idx;
    logic                hi_ok;
    logic                early;
    steer_state_t        st;
    logic [`CNT_W-1:0]   cnt;
    logic [3:0]          cand;
    logic [`SET_W-1:0]   settle;
    logic                dsteer;
    logic [3:0]          rx_data;
    logic                data_valid;
    logic                irq_pend;
    logic [1:0]          ctrl;
    logic [`CNT_W-1:0]   gtp;
    logic [`CNT_W-1:0]   gta;
    logic [`EV_W-1:0]    ev;
    logic [`EV_W-1:0]    mask;
    logic                ack;
    logic [31:0]         dat;
    logic                irq;
    logic                guard_oe;
    logic                irq_pin_oe;
  } dec_state_t;

endpackage

// file: rtl/tone_period_meter.sv
// period meter for one limited tone: counts clocks between rising edges
// assumes the tone input is already synchronous to clk_i
`timescale 1ns/1ps
`include "dtmf_map.svh"
module tone_period_meter #(
  parameter int LIMIT = 150000
) (
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire logic               tone_i,
  output logic [`PER_W-1:0]       period_o,
  output logic                    stb_o,
  output logic                    over_o
);
  import dtmf_pkg::*;

  localparam logic [`PER_W-1:0] LIM = LIMIT[`PER_W-1:0];

  meter_t q;
  meter_t d;

  always_comb begin
    d      = q;
    d.tone = tone_i;
    d.stb  = 1'b0;
    if (tone_i && !q.tone) begin
      // rising edge closes one period
      d.period = q.cnt;
      d.stb    = 1'b1;
      d.cnt    = {{(`PER_W-1){1'b0}}, 1'b1};
      d.over   = 1'b0;
    end else if (q.cnt >= LIM) begin
      // no edge for too long: tone lost
      d.over = 1'b1;
    end else begin
      d.cnt = q.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign period_o = q.period;
  assign stb_o    = q.stb;
  assign over_o   = q.over;

endmodule

// file: rtl/dtmf_receive_decode_steering.sv
// dtmf receive back end: tone classification, steering, latch and registers
// assumes limited tone inputs and steer_i synchronous to clk_i, wishbone classic
//
// The Wishbone interface to the registers and the address map were decided locally.
`timescale 1ns/1ps
`include "dtmf_map.svh"
module dtmf_receive_decode_steering #(
  parameter int CLK_FREQ   = `CLK_HZ,
  parameter int GTP_CYCLES = `GTP_TIME_US * `CLK_MHZ,
  parameter int GTA_CYCLES = `GTA_TIME_US * `CLK_MHZ
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         low_tone_i,
  input  wire logic         high_tone_i,
  input  wire logic         steer_i,
  output logic              guard_o,
  output logic              guard_oe_o,
  output logic              early_pair_valid_o,
  output logic              irq_or_progress_out_o,
  output logic              irq_or_progress_out_oe_o,
  output logic              irq_o,
  input  wire logic         wb_cyc_i,
  input  wire logic         wb_stb_i,
  input  wire logic         wb_we_i,
  input  wire logic [7:0]   wb_adr_i,
  input  wire logic [3:0]   wb_sel_i,
  input  wire logic [31:0]  wb_dat_i,
  output logic [31:0]       wb_dat_o,
  output logic              wb_ack_o
);
  import dtmf_pkg::*;

  localparam int FL [4] = '{`F_LOW0, `F_LOW1, `F_LOW2, `F_LOW3};
  localparam int FH [4] = '{`F_HIGH0, `F_HIGH1, `F_HIGH2, `F_HIGH3};
  localparam int LO_LIMIT = (CLK_FREQ / `F_LOW0) + (CLK_FREQ / `F_LOW0) / `TOL_DIV + 1;
  localparam int HI_LIMIT = (CLK_FREQ / `F_HIGH0) + (CLK_FREQ / `F_HIGH0) / `TOL_DIV + 1;
  localparam int SETTLE_INT = `SETTLE_CYC;
  localparam logic [`SET_W-1:0] SETTLE_END = SETTLE_INT[`SET_W-1:0];
  localparam logic [`CNT_W-1:0] GTP_RST = GTP_CYCLES[`CNT_W-1:0];
  localparam logic [`CNT_W-1:0] GTA_RST = GTA_CYCLES[`CNT_W-1:0];

  dec_state_t          q;
  dec_state_t          d;
  wb_req_t             req;
  logic [`PER_W-1:0]   lo_per;
  logic [`PER_W-1:0]   hi_per;
  logic                lo_stb;
  logic                hi_stb;
  logic                lo_over;
  logic                hi_over;
  logic [2:0]          lo_cls;
  logic [2:0]          hi_cls;
  logic                take;
  logic                wr;
  logic                rd_status;
  logic                ext;
  logic                present_hit;
  logic                absent_hit;
  logic [3:0]          code;
  logic [31:0]         mg;

  // classify a period against the four grid frequencies of one group
  function automatic logic [2:0] classify(input logic [`PER_W-1:0] p, input logic hi);
    int nom;
    int tol;
    logic [2:0] r;
    r = 3'h0;
    for (int i = 0; i < 4; i++) begin
      nom = CLK_FREQ / (hi ? FH[i] : FL[i]);
      tol = nom / `TOL_DIV;
      if ((int'(p) >= nom - tol) && (int'(p) <= nom + tol)) begin
        r = {1'b1, i[1:0]};
      end
    end
    return r;
  endfunction

  // digit code from low-group row and high-group column
  function automatic logic [3:0] digit_code(input logic [1:0] row, input logic [1:0] col);
    logic [3:0] c;
    case ({row, col})
      4'h0:    c = 4'h1;
      4'h1:    c = 4'h2;
      4'h2:    c = 4'h3;
      4'h3:    c = 4'hd;
      4'h4:    c = 4'h4;
      4'h5:    c = 4'h5;
      4'h6:    c = 4'h6;
      4'h7:    c = 4'he;
      4'h8:    c = 4'h7;
      4'h9:    c = 4'h8;
      4'ha:    c = 4'h9;
      4'hb:    c = 4'hf;
      4'hc:    c = 4'hb;
      4'hd:    c = 4'ha;
      4'he:    c = 4'hc;
      default: c = 4'h0;
    endcase
    return c;
  endfunction

  // byte-lane merge of a wishbone write
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return r;
  endfunction

  tone_period_meter #(
    .LIMIT    (LO_LIMIT)
  ) u_low_meter (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .tone_i   (low_tone_i),
    .period_o (lo_per),
    .stb_o    (lo_stb),
    .over_o   (lo_over)
  );

  tone_period_meter #(
    .LIMIT    (HI_LIMIT)
  ) u_high_meter (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .tone_i   (high_tone_i),
    .period_o (hi_per),
    .stb_o    (hi_stb),
    .over_o   (hi_over)
  );

  always_comb begin
    req.cyc = wb_cyc_i;
    req.stb = wb_stb_i;
    req.we  = wb_we_i;
    req.adr = wb_adr_i;
    req.sel = wb_sel_i;
    req.dat = wb_dat_i;
  end

  assign lo_cls      = classify(lo_per, 1'b0);
  assign hi_cls      = classify(hi_per, 1'b1);
  assign code        = digit_code(q.lo_idx, q.hi_idx);
  assign take        = req.cyc && req.stb && !q.ack;
  assign wr          = take && req.we;
  assign rd_status   = take && !req.we && (req.adr == `ADR_STATUS);
  assign ext         = q.ctrl[`CTRL_EXT_STEER];
  assign present_hit = ext ? steer_i : (q.cnt >= q.gtp);
  assign absent_hit  = ext ? !steer_i : (q.cnt >= q.gta);

  always_comb begin
    d     = q;
    mg    = 32'h0;
    d.ack = take;

    // tone classification per measured period
    if (lo_stb) begin
      d.lo_ok  = lo_cls[2];
      d.lo_idx = lo_cls[1:0];
    end else if (lo_over) begin
      d.lo_ok = 1'b0;
    end
    if (hi_stb) begin
      d.hi_ok  = hi_cls[2];
      d.hi_idx = hi_cls[1:0];
    end else if (hi_over) begin
      d.hi_ok = 1'b0;
    end
    d.early = q.lo_ok && q.hi_ok;

    // bus side clears first so that hardware sets below win
    if (rd_status) begin
      d.data_valid = 1'b0;
      d.irq_pend   = 1'b0;
    end
    if (wr) begin
      case (req.adr)
        `ADR_CTRL: begin
          mg     = merge({30'h0, q.ctrl}, req.dat, req.sel);
          d.ctrl = mg[1:0];
        end
        `ADR_GTP: begin
          mg    = merge({8'h0, q.gtp}, req.dat, req.sel);
          d.gtp = mg[`CNT_W-1:0];
        end
        `ADR_GTA: begin
          mg    = merge({8'h0, q.gta}, req.dat, req.sel);
          d.gta = mg[`CNT_W-1:0];
        end
        `ADR_EVENT: begin
          if (req.sel[0]) begin
            d.ev = q.ev & ~req.dat[`EV_W-1:0];
          end
        end
        `ADR_MASK: begin
          mg     = merge({29'h0, q.mask}, req.dat, req.sel);
          d.mask = mg[`EV_W-1:0];
        end
        default: begin
        end
      endcase
    end

    // steering state machine
    case (q.st)
      ST_IDLE: begin
        d.cnt = '0;
        if (q.early) begin
          d.st  = ST_PRESENT;
          d.cnt = {{(`CNT_W-1){1'b0}}, 1'b1};
        end
      end
      ST_PRESENT: begin
        if (!q.early) begin
          d.st                = ST_IDLE;
          d.ev[`EV_REJECT]    = 1'b1;
        end else if (present_hit) begin
          d.st     = ST_HELD;
          d.cand   = code;
          d.settle = '0;
          d.cnt    = '0;
        end else begin
          d.cnt = q.cnt + 1'b1;
        end
      end
      ST_HELD: begin
        d.cnt = '0;
        if (!q.early) begin
          d.st  = ST_ABSENT;
          d.cnt = {{(`CNT_W-1){1'b0}}, 1'b1};
        end
      end
      ST_ABSENT: begin
        if (q.early) begin
          d.st  = ST_HELD;
          d.cnt = '0;
        end else if (absent_hit) begin
          d.st             = ST_IDLE;
          d.dsteer         = 1'b0;
          d.settle         = SETTLE_END;
          d.ev[`EV_PAUSE]  = 1'b1;
        end else begin
          d.cnt = q.cnt + 1'b1;
        end
      end
      default: begin
        d.st  = ST_IDLE;
        d.cnt = '0;
      end
    endcase

    // settle delay, then delayed steering rises and the latch updates
    if ((q.st == ST_HELD || q.st == ST_ABSENT) && q.settle != SETTLE_END) begin
      d.settle = q.settle + 1'b1;
      if (q.settle == SETTLE_END - 1'b1) begin
        d.dsteer       = 1'b1;
        d.rx_data      = q.cand;
        d.data_valid   = 1'b1;
        d.irq_pend     = 1'b1;
        d.ev[`EV_REG]  = 1'b1;
      end
    end

    // guard output drives high while registered and early valid
    d.guard_oe   = (d.st == ST_HELD) && d.early;
    d.irq_pin_oe = q.ctrl[`CTRL_IRQ_MODE] && d.dsteer && d.irq_pend;
    d.irq        = |(d.ev & d.mask);

    // registered read data
    d.dat = 32'h0;
    if (take && !req.we) begin
      case (req.adr)
        `ADR_RX: begin
          d.dat = {28'h0, q.rx_data};
        end
        `ADR_STATUS: begin
          d.dat[`ST_EARLY]  = q.early;
          d.dat[`ST_GUARD]  = q.guard_oe;
          d.dat[`ST_VALID]  = q.data_valid;
          d.dat[`ST_DSTEER] = q.dsteer;
        end
        `ADR_CTRL: begin
          d.dat = {30'h0, q.ctrl};
        end
        `ADR_GTP: begin
          d.dat = {8'h0, q.gtp};
        end
        `ADR_GTA: begin
          d.dat = {8'h0, q.gta};
        end
        `ADR_EVENT: begin
          d.dat = {29'h0, q.ev};
        end
        `ADR_MASK: begin
          d.dat = {29'h0, q.mask};
        end
        default: begin
          d.dat = 32'h0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q        <= '0;
      q.st     <= ST_IDLE;
      q.settle <= SETTLE_END;
      q.ctrl   <= `CTRL_RST;
      q.mask   <= `MASK_RST;
      q.gtp    <= GTP_RST;
      q.gta    <= GTA_RST;
    end else begin
      q <= d;
    end
  end

  assign guard_o                  = q.guard_oe;
  assign guard_oe_o               = q.guard_oe;
  assign early_pair_valid_o       = q.early;
  assign irq_or_progress_out_o    = 1'b0;
  assign irq_or_progress_out_oe_o = q.irq_pin_oe;
  assign irq_o                    = q.irq;
  assign wb_dat_o                 = q.dat;
  assign wb_ack_o                 = q.ack;

endmodule

// file: sim/tone_line.sv
// partner model: one limited tone line, square wave of a set half period
// assumes half_i in clock cycles; zero holds the line still
`timescale 1ns/1ps
module tone_line (
  input  wire logic        clk_i,
  input  wire logic [31:0] half_i,
  output logic             tone_o
);
  logic [31:0] cnt_q = 32'h0;
  initial tone_o = 1'b0;
  always @(posedge clk_i) begin
    if (half_i == 32'h0) begin
      cnt_q <= 32'h0;
    end else if (cnt_q + 32'h1 >= half_i) begin
      cnt_q <= 32'h0;
      tone_o <= ~tone_o;
    end else begin
      cnt_q <= cnt_q + 32'h1;
    end
  end
endmodule

// file: sim/dtmf_steering_asserts.sv
// port assertions for the dtmf receive decoder
// assumes bind onto the decoder top, one clock domain
`timescale 1ns/1ps
`include "dtmf_map.svh"
module dtmf_steering_asserts (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        early_pair_valid_o,
  input wire logic        guard_o,
  input wire logic        guard_oe_o,
  input wire logic        irq_or_progress_out_o,
  input wire logic        irq_or_progress_out_oe_o,
  input wire logic        irq_o
);
  logic [7:0] run_q;
  logic [7:0] run_d;
  // length of the current early valid run, saturating
  assign run_d = !early_pair_valid_o ? 8'h0 : (run_q == 8'hff) ? run_q : run_q + 8'h1;
  always_ff @(posedge clk_i) begin
    run_q <= rst_i ? 8'h0 : run_d;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  sequence s_stat_rd;
    s_take ##0 (!wb_we_i && wb_adr_i == `ADR_STATUS);
  endsequence
  property p_ack; s_take |=> s_pulse; endproperty
  a_ack: assert property (p_ack) else $error("ack not a one cycle answer");
  property p_dat; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
  a_dat: assert property (p_dat) else $error("read data outside ack");
  property p_rst; $fell(rst_i) |-> !early_pair_valid_o && !guard_oe_o && !irq_o
    && !wb_ack_o && !irq_or_progress_out_oe_o; endproperty
  a_rst: assert property (p_rst) else $error("outputs not idle after reset");
  property p_drive; guard_oe_o |-> guard_o; endproperty
  a_drive: assert property (p_drive) else $error("guard enabled but not high");
  property p_loss; $fell(early_pair_valid_o) |-> ##[0:2] !guard_oe_o; endproperty
  a_loss: assert property (p_loss) else $error("guard held after early loss");
  // the interrupt pin enable never rises before 40 cycles of early valid here
  property p_short; $rose(irq_or_progress_out_oe_o) |-> run_q >= 8'd40; endproperty
  a_short: assert property (p_short) else $error("registered a short tone");
  property p_settle; $rose(guard_oe_o) && !irq_or_progress_out_oe_o |->
    !irq_or_progress_out_oe_o [*8]; endproperty
  a_settle: assert property (p_settle) else $error("flag without settle delay");
  property p_pin; irq_or_progress_out_oe_o |-> !irq_or_progress_out_o; endproperty
  a_pin: assert property (p_pin) else $error("interrupt pin not pulled low");
  property p_clr; s_stat_rd |-> ##[1:2] !irq_or_progress_out_oe_o; endproperty
  a_clr: assert property (p_clr) else $error("status read left pin low");
endmodule
bind dtmf_receive_decode_steering dtmf_steering_asserts chk (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .early_pair_valid_o(early_pair_valid_o),
  .guard_o(guard_o), .guard_oe_o(guard_oe_o), .irq_or_progress_out_o(irq_or_progress_out_o),
  .irq_or_progress_out_oe_o(irq_or_progress_out_oe_o), .irq_o(irq_o));

// file: sim/dtmf_receive_decode_steering_test.sv
// self-checking bench for the dtmf receive decoder over wishbone
// assumes the tone_line partner and the bound checker
`timescale 1ns/1ps
`include "dtmf_map.svh"
module dtmf_receive_decode_steering_test;
  localparam int GT = 50;
  localparam int SIM_HZ = 1000000;
  logic        steer = 1'b0;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, seen_g = 1'b0;
  logic [7:0]  adr = 8'h0;
  logic [31:0] wdat = 32'h0, lo_h = 32'h0, hi_h = 32'h0, rdat;
  logic        lo_t, hi_t, g, g_oe, early, pin, pin_oe, irq, ack;
  int          errors = 0;
  int          comparisons = 0;
  initial forever #5 clk_i = ~clk_i;
  tone_line lo_src (.clk_i(clk_i), .half_i(lo_h), .tone_o(lo_t));
  tone_line hi_src (.clk_i(clk_i), .half_i(hi_h), .tone_o(hi_t));
  dtmf_receive_decode_steering #(.CLK_FREQ(SIM_HZ), .GTP_CYCLES(GT), .GTA_CYCLES(GT)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .low_tone_i(lo_t), .high_tone_i(hi_t),
    .steer_i(steer), .guard_o(g), .guard_oe_o(g_oe), .early_pair_valid_o(early),
    .irq_or_progress_out_o(pin), .irq_or_progress_out_oe_o(pin_oe), .irq_o(irq),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack));
  always @(posedge clk_i) if (g_oe === 1'b1) seen_g <= 1'b1;
  function automatic logic [31:0] hp(input int f);
    return 32'(SIM_HZ / (2 * f));
  endfunction
  function automatic logic pv(input int k);
    logic [3:0] s;
    s = {irq, pin_oe, g_oe, early};
    return s[k];
  endfunction
  task automatic close_out;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk_i);
    if (n >= 50) errors++;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0, q);
    chk(nm, q, e);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask
  task automatic wt(input int k, input logic v, input int lim);
    int n;
    n = 0;
    while (pv(k) !== v && n < lim) begin
      @(posedge clk_i);
      n++;
    end
    chk("port wait", {31'h0, pv(k)}, {31'h0, v});
  endtask
  task automatic t_reset;
    rd(`ADR_RX, 32'h0, "rx");
    rd(`ADR_STATUS, 32'h0, "status");
    rd(`ADR_CTRL, 32'h0, "ctrl");
    rd(`ADR_GTP, 32'(GT), "gtp");
    rd(`ADR_GTA, 32'(GT), "gta");
    rd(`ADR_EVENT, 32'h0, "event");
    rd(`ADR_MASK, 32'h0, "mask");
    wr(`ADR_RX, 32'h5);
    wr(8'h1c, 32'hf);
    rd(`ADR_RX, 32'h0, "rx read only");
    rd(8'h1c, 32'h0, "unmapped");
  endtask
  task automatic t_reg(input int fl, input int fh, input logic [3:0] code, input logic m);
    lo_h <= hp(fl);
    hi_h <= hp(fh);
    wt(0, 1'b1, 8000);
    wt(1, 1'b1, 400);
    repeat (20) @(posedge clk_i);
    chk("pin", {31'h0, pin_oe}, {31'h0, m});
    chk("irq", {31'h0, irq}, {31'h0, m});
    rd(`ADR_RX, {28'h0, code}, "code");
    rd(`ADR_STATUS, 32'hf, "status set");
    chk("pin read", {31'h0, pin_oe}, 32'h0);
    rd(`ADR_STATUS, 32'hb, "status read");
    rd(`ADR_EVENT, 32'h1, "event reg");
    wr(`ADR_EVENT, 32'h1);
    wt(3, 1'b0, 4);
  endtask
  task automatic t_end(input logic [3:0] code);
    lo_h <= 32'h0;
    hi_h <= 32'h0;
    wt(0, 1'b0, 8000);
    wt(1, 1'b0, 4);
    repeat (GT + 20) @(posedge clk_i);
    rd(`ADR_STATUS, 32'h0, "status end");
    rd(`ADR_EVENT, 32'h2, "event pause");
    wr(`ADR_EVENT, 32'h2);
    rd(`ADR_RX, {28'h0, code}, "rx kept");
  endtask
  task automatic t_star;
    wr(`ADR_CTRL, 32'h1);
    wr(`ADR_MASK, 32'h7);
    t_reg(941, 1209, 4'hb, 1'b1);
    t_end(4'hb);
  endtask
  task automatic t_dropout;
    wr(`ADR_GTA, 32'h1000);
    t_reg(941, 1633, 4'h0, 1'b1);
    hi_h <= hp(1633) >> 1;
    wt(0, 1'b0, 4000);
    hi_h <= hp(1633);
    wt(1, 1'b0, 4);
    rd(`ADR_STATUS, 32'h8, "status drop");
    wt(0, 1'b1, 4000);
    wt(1, 1'b1, 4);
    rd(`ADR_EVENT, 32'h0, "event drop");
    rd(`ADR_RX, 32'h0, "rx drop");
    wr(`ADR_GTA, 32'(GT));
    t_end(4'h0);
  endtask
  task automatic t_reject;
    wr(`ADR_GTP, 32'h1000);
    seen_g <= 1'b0;
    lo_h <= hp(852);
    hi_h <= hp(1477);
    wt(0, 1'b1, 8000);
    hi_h <= hp(1477) >> 1;
    wt(0, 1'b0, 4000);
    lo_h <= 32'h0;
    hi_h <= 32'h0;
    rd(`ADR_EVENT, 32'h4, "event reject");
    wt(3, 1'b1, 4);
    chk("guard reject", {31'h0, seen_g}, 32'h0);
    rd(`ADR_RX, 32'h0, "rx reject");
    wr(`ADR_EVENT, 32'h4);
    wr(`ADR_GTP, 32'(GT));
    repeat (3000) @(posedge clk_i);
  endtask
  task automatic t_ext;
    wr(`ADR_CTRL, 32'h2);
    lo_h <= hp(770);
    hi_h <= hp(1336);
    wt(0, 1'b1, 8000);
    repeat (100) @(posedge clk_i);
    chk("guard no steer", {31'h0, g_oe}, 32'h0);
    steer <= 1'b1;
    wt(1, 1'b1, 8);
    repeat (20) @(posedge clk_i);
    rd(`ADR_RX, 32'h5, "rx ext");
    lo_h <= 32'h0;
    hi_h <= 32'h0;
    wt(0, 1'b0, 8000);
    repeat (100) @(posedge clk_i);
    rd(`ADR_STATUS, 32'hc, "status steer held");
    steer <= 1'b0;
    repeat (5) @(posedge clk_i);
    rd(`ADR_STATUS, 32'h0, "status steer low");
    rd(`ADR_EVENT, 32'h3, "event ext");
    wr(`ADR_EVENT, 32'h3);
    wr(`ADR_CTRL, 32'h0);
  endtask
  task automatic t_plain;
    wr(`ADR_CTRL, 32'h0);
    wr(`ADR_MASK, 32'h0);
    t_reg(852, 1477, 4'h9, 1'b0);
    t_end(4'h9);
  endtask
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_star();
    t_dropout();
    t_reject();
    t_plain();
    t_ext();
    close_out();
  end
  initial begin
    #900000;
    errors++;
    close_out();
  end
endmodule
